// ### bench/bert_line_model.sv
`timescale 1ns/1ps
module bert_line_model (
  // clock and reset
  input  wire logic CLK,
  input  wire logic RST,
  // bench control: send bits, corrupt bits
  input  wire logic run,
  input  wire logic err,
  // stream and aligner toward the block
  input  wire logic RESYNC_REQ,
  output logic      BIT_VALID,
  output logic      BIT_RX,
  output logic      BIT_EXP,
  output logic      PATTERN_LOCK
);
  logic [14:0] lfsr_r;
  logic [5:0]  hunt_r;
  // prbs bits; idle lines toggle so nothing stale lingers
  always_ff @(posedge CLK) begin
    if (RST) begin
      lfsr_r    <= 15'h0001;
      BIT_VALID <= 1'b0;
      BIT_RX    <= 1'b0;
      BIT_EXP   <= 1'b1;
    end else begin
      lfsr_r    <= run ? {lfsr_r[13:0], lfsr_r[14] ^ lfsr_r[13]} : lfsr_r;
      BIT_VALID <= run;
      BIT_EXP   <= run ? lfsr_r[0] : ~BIT_EXP;
      BIT_RX    <= run ? lfsr_r[0] ^ err : ~BIT_RX;
    end
  end
  // aligner drops lock on rehunt, relocks after a clean stretch
  always_ff @(posedge CLK) begin
    if (RST) begin
      PATTERN_LOCK <= 1'b0;
      hunt_r       <= 6'h0;
    end else if (RESYNC_REQ || err) begin
      PATTERN_LOCK <= PATTERN_LOCK & ~RESYNC_REQ;
      hunt_r       <= 6'h28;
    end else if (hunt_r != 6'h0) begin
      hunt_r <= hunt_r - 6'h1;
    end else if (run) begin
      PATTERN_LOCK <= 1'b1;
    end
  end
endmodule

// ### bench/bert_stats_asserts.sv
`timescale 1ns/1ps
module bert_stats_asserts #(
  parameter int SEC_CYC = bert_pkg::SEC_CYC
) (
  // clock, reset and watched inputs
  input logic                     CLK,
  input logic                     RST,
  input logic                     TEST_START,
  input logic                     BIT_VALID,
  // status and log entry
  input bert_pkg::state_t         TEST_STATE,
  input logic                     RESYNC_REQ,
  input logic                     LOG_VALID,
  input logic [4:0]               LOG_NUM,
  input logic [bert_pkg::K_N-1:0] LOG_KIND,
  input logic [47:0]              LOG_BITS,
  input logic [47:0]              LOG_BIT_ERRS,
  input logic [15:0]              LOG_BER,
  input logic [31:0]              LOG_BLOCKS,
  input logic [31:0]              LOG_BLK_ERRS,
  input logic [15:0]              LOG_BLOCK_ERROR_RATIO,
  input logic [15:0]              LOG_SYNC_LOSSES,
  input logic [31:0]              LOG_ERR_SECS,
  input logic [6:0]               LOG_EFS_PCT,
  input logic [5:0]               LOG_MINUTES,
  input logic [5:0]               LOG_SECONDS
);
  logic [31:0] idle_r;
  // cycles since the last received bit
  always_ff @(posedge CLK) begin
    if (RST || BIT_VALID) idle_r <= 32'h0;
    else if (idle_r != 32'hffff_ffff) idle_r <= idle_r + 32'h1;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  a_start_wait: assert property (TEST_START |-> ##[1:3] TEST_STATE == bert_pkg::ST_WAIT)
    else $error("state not waiting after start");
  a_loss_state: assert property ($rose(RESYNC_REQ) |-> ##[0:2] TEST_STATE == bert_pkg::ST_LOST)
    else $error("rehunt without lost state");
  a_entry_once: assert property (LOG_VALID |=> !LOG_VALID [*8])
    else $error("log entries too close");
  a_num_range: assert property (LOG_VALID |-> LOG_NUM >= 5'h1 && LOG_NUM <= 5'h19)
    else $error("event number out of range");
  a_lost_count: assert property (LOG_VALID && LOG_KIND[0] |-> LOG_SYNC_LOSSES != 16'h0)
    else $error("lost entry without loss count");
  a_errsec_count: assert property (LOG_VALID && LOG_KIND[3] |-> LOG_ERR_SECS != 32'h0
    && LOG_BIT_ERRS != 48'h0) else $error("errored second not counted");
  a_ber_zero: assert property (LOG_VALID |-> LOG_BIT_ERRS <= LOG_BITS
    && (LOG_BIT_ERRS != 48'h0 || LOG_BER == 16'h0)) else $error("bit error ratio wrong");
  a_block_error_ratio_zero: assert property (LOG_VALID |-> LOG_BLK_ERRS <= LOG_BLOCKS
    && (LOG_BLK_ERRS != 32'h0 || LOG_BLOCK_ERROR_RATIO == 16'h0)) else $error("block error ratio wrong");
  a_efs_full: assert property (LOG_VALID |-> LOG_EFS_PCT <= 7'h64
    && (LOG_ERR_SECS != 32'h0 || LOG_EFS_PCT == 7'h64)) else $error("error free percent wrong");
  a_time_range: assert property (LOG_VALID |-> LOG_SECONDS <= 6'h3b && LOG_MINUTES <= 6'h3b)
    else $error("elapsed time field out of range");
  a_idle_dint: assert property (!((TEST_STATE == bert_pkg::ST_SYNC
    || TEST_STATE == bert_pkg::ST_RECOV) && idle_r > SEC_CYC + 4)) else $error("no data not shown");
endmodule
bind bert_stats bert_stats_asserts #(.SEC_CYC(SEC_CYC)) i_asserts (
  .CLK(CLK), .RST(RST), .TEST_START(TEST_START), .BIT_VALID(BIT_VALID),
  .TEST_STATE(TEST_STATE), .RESYNC_REQ(RESYNC_REQ), .LOG_VALID(LOG_VALID),
  .LOG_NUM(LOG_NUM), .LOG_KIND(LOG_KIND), .LOG_BITS(LOG_BITS), .LOG_BIT_ERRS(LOG_BIT_ERRS),
  .LOG_BER(LOG_BER), .LOG_BLOCKS(LOG_BLOCKS), .LOG_BLK_ERRS(LOG_BLK_ERRS), .LOG_BLOCK_ERROR_RATIO(LOG_BLOCK_ERROR_RATIO),
  .LOG_SYNC_LOSSES(LOG_SYNC_LOSSES), .LOG_ERR_SECS(LOG_ERR_SECS), .LOG_EFS_PCT(LOG_EFS_PCT),
  .LOG_MINUTES(LOG_MINUTES), .LOG_SECONDS(LOG_SECONDS)
);

// ### bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic             clk, rst, start, stop, par_en, par_odd, char_msg, char_done, char_xor;
  logic             mains_ok, pbusy, ptake, run, err, bv, brx, bexp, lock, resync, pmark, lv;
  logic [23:0]      blen;
  logic [4:0]       num;
  logic [6:0]       kind, efs;
  logic [47:0]      bits, berrs;
  logic [15:0]      ber, block_error_ratio, slos, plos, hrs;
  logic [31:0]      blks, blkerrs, perrs, esecs;
  logic [5:0]       mins, secs;
  bert_pkg::state_t st;
  int               num_errors, cmp_count, seed, n, pe, entries, t0, i;
  logic             got, x;
  // design with short second and power-loss counts
  bert_stats #(.SEC_CYC(200), .PLOSS_CYC(10)) i_bert_stats (
    .CLK(clk), .RST(rst), .TEST_START(start), .TEST_STOP(stop), .PARITY_EN(par_en),
    .PARITY_ODD(par_odd), .CHAR_MSG(char_msg), .BLOCK_LEN(blen), .BIT_VALID(bv),
    .BIT_RX(brx), .BIT_EXP(bexp), .PATTERN_LOCK(lock), .CHAR_DONE(char_done),
    .CHAR_XOR(char_xor), .MAINS_OK(mains_ok), .PRINT_BUSY(pbusy), .PRINT_TAKE(ptake),
    .TEST_STATE(st), .RESYNC_REQ(resync), .PRINT_MARK(pmark), .LOG_VALID(lv),
    .LOG_NUM(num), .LOG_KIND(kind), .LOG_BITS(bits), .LOG_BIT_ERRS(berrs), .LOG_BER(ber),
    .LOG_BLOCKS(blks), .LOG_BLK_ERRS(blkerrs), .LOG_BLOCK_ERROR_RATIO(block_error_ratio), .LOG_PAR_ERRS(perrs),
    .LOG_SYNC_LOSSES(slos), .LOG_ERR_SECS(esecs), .LOG_EFS_PCT(efs), .LOG_PWR_LOSSES(plos),
    .LOG_HOURS(hrs), .LOG_MINUTES(mins), .LOG_SECONDS(secs));
  // channel under test
  bert_line_model i_bert_line_model (.CLK(clk), .RST(rst), .run(run), .err(err),
    .RESYNC_REQ(resync), .BIT_VALID(bv), .BIT_RX(brx), .BIT_EXP(bexp), .PATTERN_LOCK(lock));
  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // count every log entry
  always @(posedge clk) if (lv === 1'b1) entries <= entries + 1;
  // verdict and end of run
  task automatic complete_run();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // one comparison
  task automatic chk(input logic ok);
    cmp_count++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("ERROR %0t check %0d mismatched", $time, cmp_count);
    end
  endtask
  // wait for the next log entry, bounded
  task automatic wait_log(input int lim);
    got = 1'b0;
    for (int k = 0; k < lim && !got; k++) begin
      @(posedge clk);
      #1;
      got = (lv === 1'b1);
    end
  endtask
  // corrupt c consecutive bits
  task automatic hit(input int c);
    @(posedge clk) err <= 1'b1;
    repeat (c) @(posedge clk);
    err <= 1'b0;
  endtask
  // errs over total as a 16-bit fraction
  function automatic logic [15:0] ratio(input logic [47:0] a, input logic [47:0] b);
    logic [63:0] q;
    q = {a, 16'h0} / {16'h0, b};
    ratio = (q > 64'hffff) ? 16'hffff : q[15:0];
  endfunction
  function automatic int tsec();
    tsec = int'(mins) * 60 + int'(secs);
  endfunction
  // watchdog
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    $display("ERROR %0t watchdog expired", $time);
    complete_run();
  end
  // main sequence
  initial begin
    seed = 69;
    {rst, start, stop, par_en, par_odd, char_msg, char_done, char_xor} = 8'h80;
    {mains_ok, pbusy, ptake, run, err} = 5'h10;
    blen = 24'h64 + 24'($random(seed) & 63);
    {entries, num_errors, cmp_count} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    run <= 1'b1;
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    repeat (5) @(posedge clk);
    #1 chk(st === bert_pkg::ST_SYNC);
    // burst of errors mid-second
    repeat (410) @(posedge clk);
    n = 1 + ($random(seed) & 3);
    hit(n);
    wait_log(400);
    chk(got && kind === 7'h08 && berrs === 48'(n) && esecs === 32'h1);
    chk(ber === ratio(berrs, bits) && blks === 32'(bits / blen));
    chk(blkerrs >= 1 && blkerrs <= 2 && block_error_ratio === ratio(48'(blkerrs), 48'(blks)));
    chk(efs === 7'((tsec() - 1) * 100 / tsec()));
    // clean second, then sync loss and recovery
    t0 = tsec();
    repeat (198) @(posedge clk);
    fork
      hit(300);
    join_none
    wait_log(400);
    chk(got && kind[0] === 1'b1 && slos === 16'h1 && esecs === 32'h1);
    wait_log(400);
    chk(got && kind[1] === 1'b1 && berrs === 48'(n));
    chk(st === bert_pkg::ST_RECOV && tsec() === t0 + 3 && hrs === 16'h0);
    // parity on, then off
    {par_en, par_odd, char_msg} <= 3'h7;
    pe = 0;
    for (i = 0; i < 8; i++) begin
      x = (i == 0) ? 1'b0 : 1'($random(seed));
      pe += int'(!x && i < 4);
      @(posedge clk) {char_done, char_xor} <= {1'b1, x};
      @(posedge clk) char_done <= 1'b0;
      if (i == 3) par_en <= (pe == 0);
    end
    par_en <= 1'b1;
    wait_log(400);
    chk(got && kind === 7'h10 && perrs === 32'(pe));
    par_en <= 1'b0;
    repeat (3) begin
      @(posedge clk) {char_done, char_xor} <= 2'h2;
      @(posedge clk) char_done <= 1'b0;
    end
    wait_log(450);
    chk(!got);
    // data interrupted
    run <= 1'b0;
    wait_log(500);
    chk(got && kind[2] === 1'b1 && st === bert_pkg::ST_DINT);
    run <= 1'b1;
    // short outage, then long outage
    repeat (5) @(posedge clk);
    mains_ok <= 1'b0;
    repeat (30) @(posedge clk);
    mains_ok <= 1'b1;
    wait_log(400);
    chk(got && kind === 7'h40 && plos === 16'h1);
    mains_ok <= 1'b0;
    wait_log(500);
    chk(got && kind[5] === 1'b1 && st === bert_pkg::ST_PFAIL);
    mains_ok <= 1'b1;
    wait_log(400);
    chk(got && kind[6] === 1'b1 && plos === 16'h2);
    // two errored seconds while printing
    pbusy <= 1'b1;
    repeat (2) begin
      hit(1);
      wait_log(400);
    end
    repeat (2) @(posedge clk);
    #1 chk(pmark === 1'b1);
    @(posedge clk) ptake <= 1'b1;
    @(posedge clk) ptake <= 1'b0;
    pbusy <= 1'b0;
    @(posedge clk);
    #1 chk(pmark === 1'b0);
    // fill the event log past its limit
    for (i = 0; i < 20; i++) begin
      hit(1);
      wait_log(300);
    end
    chk(entries === 25 && num === 5'h19);
    // stop, restart with default block length
    @(posedge clk) stop <= 1'b1;
    @(posedge clk) stop <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(st === bert_pkg::ST_END);
    blen <= 24'h0;
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    repeat (1300) @(posedge clk);
    hit(1);
    wait_log(400);
    chk(got && num === 5'h1 && berrs === 48'h1 && slos === 16'h0);
    chk(plos === 16'h0 && perrs === 32'h0 && blks === 32'(bits / 1000));
    complete_run();
  end
endmodule

// ### hw/bert_pkg.sv
package bert_pkg;
  // clock and timing
  localparam int CLK_HZ      = 10_000_000;
  localparam int MS_PER_S    = 1000;
  localparam int SEC_MS      = 1000;
  localparam int PLOSS_MS    = 50;
  localparam int SEC_CYC     = CLK_HZ / MS_PER_S * SEC_MS;
  localparam int PLOSS_CYC   = (CLK_HZ / MS_PER_S * PLOSS_MS + 0);
  // counter widths
  localparam int BITS_W      = 48;
  localparam int CNT_W       = 32;
  localparam int SHORT_W     = 16;
  localparam int SEC_W       = 24;
  localparam int FRAC_W      = 16;
  // block length limits and default
  localparam logic [23:0] BLK_MIN = 24'h64;
  localparam logic [23:0] BLK_MAX = 24'h98_9680;
  localparam logic [23:0] BLK_DEF = 24'h3e8;
  // sync loss when errors times this exceed bits (above 20 percent)
  localparam logic [26:0] LOSS_MUL = 27'h5;
  localparam logic [4:0]  MAX_EVENTS = 5'h19;
  localparam logic [39:0] PCT_FULL   = 40'h64;
  // event kind bit positions
  localparam int K_LOST   = 0;
  localparam int K_RECOV  = 1;
  localparam int K_DINT   = 2;
  localparam int K_ERRSEC = 3;
  localparam int K_PAR    = 4;
  localparam int K_PFAIL  = 5;
  localparam int K_PREST  = 6;
  localparam int K_N      = 7;
  // elapsed time minute and second rollover
  localparam logic [5:0] SIXTY_M1 = 6'h3b;

  typedef enum logic [2:0] {
    ST_WAIT, ST_SYNC, ST_LOST, ST_RECOV, ST_DINT, ST_PFAIL, ST_PREST, ST_END
  } state_t;

  typedef struct packed {
    logic [BITS_W-1:0] bits;
    logic [BITS_W-1:0] berr;
    logic [CNT_W-1:0]  blk;
    logic [CNT_W-1:0]  blkerr;
    logic [CNT_W-1:0]  par;
    logic [CNT_W-1:0]  es;
    logic [CNT_W-1:0]  ins;
    logic [CNT_W-1:0]  efs;
  } stats_t;
endpackage

// ### hw/bert_stats.sv
// Operation
// - over 20 percent bit errors in a second declares sync loss and logs it
// - no data for one second logs data interrupted and shows it as status
// - each second with a bit error, other than a sync-loss second, is an errored second and is logged
// - a second with parity errors is logged only when parity is enabled
// - character messages: one parity count per mismatching character, none if disabled
// - over one second off logs power failed; return logs power restored once
// - mains off longer than 50 ms is one power loss and counts one
// - status: wait, synced, lost, recovered, interrupted, power failed, restored, end
// - running total of all bits received while synced or recovered
// - one bit error count per received bit differing from expected
// - event log updated once per second, aggregating that second's errors
// - bit error ratio is bit errors over bits, stored with each event
// - blocks counted with length 100 to ten million bits, default 1000
// - one block error per completed block holding any bit error
// - block error ratio is block errors over blocks
// - elapsed time runs from first sync, logged as hours minutes seconds
// - percent error-free seconds over in-service seconds, sync-lost seconds excluded
// - on recovery statistics return to the last error-free second, time keeps running
// - skipped results during printing mark the next status line with asterisk
// - at most 25 numbered events per test
// - test start clears every counter except the free timebase; the log outputs keep the last entry until the next one
`timescale 1ns/1ps
module bert_stats #(
  parameter int SEC_CYC   = bert_pkg::SEC_CYC,
  parameter int PLOSS_CYC = bert_pkg::PLOSS_CYC
) (
  // clock and reset
  input  wire logic                          CLK,
  input  wire logic                          RST,
  // test control and setup
  input  wire logic                          TEST_START,
  input  wire logic                          TEST_STOP,
  input  wire logic                          PARITY_EN,
  input  wire logic                          PARITY_ODD,
  input  wire logic                          CHAR_MSG,
  input  wire logic [23:0]                   BLOCK_LEN,
  // received stream from pattern logic
  input  wire logic                          BIT_VALID,
  input  wire logic                          BIT_RX,
  input  wire logic                          BIT_EXP,
  input  wire logic                          PATTERN_LOCK,
  input  wire logic                          CHAR_DONE,
  input  wire logic                          CHAR_XOR,
  // mains sense pin
  input  wire logic                          MAINS_OK,
  // printer handshake
  input  wire logic                          PRINT_BUSY,
  input  wire logic                          PRINT_TAKE,
  // status
  output bert_pkg::state_t                   TEST_STATE,
  output logic                               RESYNC_REQ,
  output logic                               PRINT_MARK,
  // event log entry
  output logic                               LOG_VALID,
  output logic [4:0]                         LOG_NUM,
  output logic [bert_pkg::K_N-1:0]           LOG_KIND,
  output logic [bert_pkg::BITS_W-1:0]        LOG_BITS,
  output logic [bert_pkg::BITS_W-1:0]        LOG_BIT_ERRS,
  output logic [bert_pkg::FRAC_W-1:0]        LOG_BER,
  output logic [bert_pkg::CNT_W-1:0]         LOG_BLOCKS,
  output logic [bert_pkg::CNT_W-1:0]         LOG_BLK_ERRS,
  output logic [bert_pkg::FRAC_W-1:0]        LOG_BLOCK_ERROR_RATIO,
  output logic [bert_pkg::CNT_W-1:0]         LOG_PAR_ERRS,
  output logic [bert_pkg::SHORT_W-1:0]       LOG_SYNC_LOSSES,
  output logic [bert_pkg::CNT_W-1:0]         LOG_ERR_SECS,
  output logic [6:0]                         LOG_EFS_PCT,
  output logic [bert_pkg::SHORT_W-1:0]       LOG_PWR_LOSSES,
  output logic [bert_pkg::SHORT_W-1:0]       LOG_HOURS,
  output logic [5:0]                         LOG_MINUTES,
  output logic [5:0]                         LOG_SECONDS
);

  // elaboration check on timing parameters
  if (SEC_CYC < 4 || PLOSS_CYC < 2 || PLOSS_CYC >= SEC_CYC ||
      SEC_CYC >= (1 << bert_pkg::SEC_W)) begin : g_bad
    $error("bert_stats: timing parameters out of range");
  end

  // ratio as unsigned fraction of one, saturating at all ones
  function automatic logic [15:0] frac(input logic [47:0] n, input logic [47:0] d);
    logic [63:0] q;
    q = '0;
    if (d != '0) begin
      q = {n, 16'h0} / {16'h0, d};
    end
    return (q > 64'hffff) ? 16'hffff : q[15:0];
  endfunction

  // whole percent, full when nothing counted yet
  function automatic logic [6:0] pct(input logic [31:0] n, input logic [31:0] d);
    logic [39:0] q;
    q = bert_pkg::PCT_FULL;
    if (d != '0) begin
      q = ({8'h0, n} * bert_pkg::PCT_FULL) / {8'h0, d};
    end
    return q[6:0];
  endfunction

  localparam logic [31:0] SEC_LAST   = 32'(SEC_CYC - 1);
  localparam logic [31:0] PLOSS_LAST = 32'(PLOSS_CYC - 1);

  logic [31:0]                 div_r;
  logic                        tick_r;
  logic                        m_s1_r, m_s2_r, m_s3_r, mains_r;
  logic [31:0]                 pdn_r;
  logic                        plost_r, pfail_r, prest_show_r;
  logic                        pf_pend_r, pr_pend_r, di_pend_r, rc_pend_r;
  logic [31:0]                 idle_r;
  logic                        dint_r;
  logic                        run_r, ended_r;
  bert_pkg::state_t            sync_r;
  logic                        lock_d_r;
  logic [bert_pkg::SEC_W-1:0]  sec_bits_r, sec_errs_r;
  logic                        sec_par_r;
  bert_pkg::stats_t            st_r, ck_r;
  logic                        ck_go_r;
  logic [23:0]                 blkpos_r;
  logic                        blkhit_r;
  logic [15:0]                 sl_r, pl_r;
  logic [15:0]                 hr_r;
  logic [5:0]                  mn_r, sc_r;
  logic                        log_go_r;
  logic [bert_pkg::K_N-1:0]    kind_r;
  logic [4:0]                  num_r;
  logic                        ppend_r;

  // decoded conditions
  wire in_svc  = run_r & (sync_r == bert_pkg::ST_SYNC | sync_r == bert_pkg::ST_RECOV);
  wire bit_w   = in_svc & BIT_VALID;
  wire err_w   = bit_w & (BIT_RX ^ BIT_EXP);
  wire par_w   = in_svc & CHAR_DONE & CHAR_MSG & PARITY_EN & (CHAR_XOR ^ PARITY_ODD);
  wire over_w  = (27'(sec_errs_r) * bert_pkg::LOSS_MUL) > 27'(sec_bits_r);
  wire loss_w  = tick_r & in_svc & (sec_bits_r != '0) & over_w;
  wire svc_w   = tick_r & in_svc & ~loss_w;
  wire es_w    = svc_w & (sec_errs_r != '0);
  wire recov_w = run_r & (sync_r == bert_pkg::ST_LOST) & PATTERN_LOCK & ~lock_d_r;
  wire dset_w  = run_r & ~BIT_VALID & ~dint_r & (idle_r == SEC_LAST);
  wire lset_w  = ~mains_r & (pdn_r == PLOSS_LAST);
  wire fset_w  = ~mains_r & (pdn_r == SEC_LAST) & ~pfail_r;   // once per outage
  wire rset_w  = mains_r & plost_r;
  wire [23:0] blen_w = (BLOCK_LEN == '0) ? bert_pkg::BLK_DEF :
                       (BLOCK_LEN < bert_pkg::BLK_MIN) ? bert_pkg::BLK_MIN :
                       (BLOCK_LEN > bert_pkg::BLK_MAX) ? bert_pkg::BLK_MAX : BLOCK_LEN;
  wire blk_end = bit_w & (blkpos_r == blen_w - 24'h1);
  wire [bert_pkg::K_N-1:0] kind_w = {
    pr_pend_r | (rset_w & run_r),
    pf_pend_r,
    svc_w & sec_par_r & PARITY_EN,
    es_w,
    di_pend_r | dset_w,
    rc_pend_r,
    loss_w
  };
  wire log_w   = tick_r & run_r & (kind_w != '0) & (num_r < bert_pkg::MAX_EVENTS);

  // free one-second timebase
  always_ff @(posedge CLK) begin
    if (RST) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (div_r == SEC_LAST);
      div_r  <= (div_r == SEC_LAST) ? '0 : div_r + 32'h1;
    end
  end

  // mains pin synchroniser, change taken when stages two and three agree
  always_ff @(posedge CLK) begin
    if (RST) begin
      m_s1_r  <= 1'b1;
      m_s2_r  <= 1'b1;
      m_s3_r  <= 1'b1;
      mains_r <= 1'b1;
    end else begin
      m_s1_r <= MAINS_OK;
      m_s2_r <= m_s1_r;
      m_s3_r <= m_s2_r;
      if (m_s2_r == m_s3_r) begin
        mains_r <= m_s3_r;
      end
    end
  end

  // power outage timing and counting
  always_ff @(posedge CLK) begin
    if (RST || TEST_START) begin
      pdn_r   <= '0;
      plost_r <= 1'b0;
      pfail_r <= 1'b0;
      pl_r    <= '0;
    end else begin
      pdn_r <= (mains_r || pdn_r == SEC_LAST) ? (mains_r ? '0 : pdn_r) : pdn_r + 32'h1;
      if (lset_w) begin
        plost_r <= 1'b1;
        pl_r    <= pl_r + (run_r ? 16'h1 : 16'h0);
      end else if (rset_w) begin
        plost_r <= 1'b0;
      end
      pfail_r <= fset_w | (pfail_r & ~mains_r);
    end
  end

  // pending events wait for the next tick; a new set wins over the clear, except pr_pend_r and di_pend_r, whose set at a tick logs directly
  always_ff @(posedge CLK) begin
    if (RST || TEST_START) begin
      pf_pend_r    <= 1'b0;
      pr_pend_r    <= 1'b0;
      di_pend_r    <= 1'b0;
      rc_pend_r    <= 1'b0;
      prest_show_r <= 1'b0;
    end else begin
      pf_pend_r    <= (fset_w & run_r) | (pf_pend_r & ~tick_r);
      pr_pend_r    <= (rset_w & run_r & ~tick_r) | (pr_pend_r & ~tick_r);
      di_pend_r    <= (dset_w & ~tick_r) | (di_pend_r & ~tick_r);
      rc_pend_r    <= recov_w | (rc_pend_r & ~tick_r);
      prest_show_r <= rset_w | (prest_show_r & ~tick_r);
    end
  end

  // data absence detection
  always_ff @(posedge CLK) begin
    if (RST || TEST_START) begin
      idle_r <= '0;
      dint_r <= 1'b0;
    end else begin
      idle_r <= (BIT_VALID || !run_r) ? '0 : (idle_r == SEC_LAST ? idle_r : idle_r + 32'h1);
      dint_r <= dset_w | (dint_r & ~BIT_VALID & run_r);
    end
  end

  // test run and sync tracking
  always_ff @(posedge CLK) begin
    if (RST) begin
      run_r    <= 1'b0;
      ended_r  <= 1'b0;
      sync_r   <= bert_pkg::ST_WAIT;
      lock_d_r <= 1'b0;
      sl_r     <= '0;
    end else if (TEST_START) begin
      run_r    <= 1'b1;
      ended_r  <= 1'b0;
      sync_r   <= bert_pkg::ST_WAIT;
      lock_d_r <= PATTERN_LOCK;
      sl_r     <= '0;
    end else begin
      lock_d_r <= PATTERN_LOCK;
      if (TEST_STOP && run_r) begin
        run_r   <= 1'b0;
        ended_r <= 1'b1;
      end
      case (sync_r)
        bert_pkg::ST_WAIT: begin
          if (run_r && PATTERN_LOCK) begin
            sync_r <= bert_pkg::ST_SYNC;
          end
        end
        bert_pkg::ST_SYNC, bert_pkg::ST_RECOV: begin
          if (loss_w) begin
            sync_r <= bert_pkg::ST_LOST;
            sl_r   <= sl_r + 16'h1;
          end
        end
        bert_pkg::ST_LOST: begin
          if (recov_w) begin
            sync_r <= bert_pkg::ST_RECOV;
          end
        end
        default: sync_r <= bert_pkg::ST_WAIT;
      endcase
    end
  end

  // per-second tallies for the interval in progress
  always_ff @(posedge CLK) begin
    if (RST || TEST_START || tick_r) begin
      sec_bits_r <= '0;
      sec_errs_r <= '0;
      sec_par_r  <= 1'b0;
    end else begin
      sec_bits_r <= sec_bits_r + (bit_w ? 24'h1 : 24'h0);
      sec_errs_r <= sec_errs_r + (err_w ? 24'h1 : 24'h0);
      sec_par_r  <= sec_par_r | par_w;
    end
  end

  // cumulative statistics with checkpoint and restore
  always_ff @(posedge CLK) begin
    if (RST || TEST_START) begin
      st_r     <= '0;
      ck_r     <= '0;
      ck_go_r  <= 1'b0;
      blkpos_r <= '0;
      blkhit_r <= 1'b0;
    end else if (recov_w) begin
      st_r     <= ck_r;
      ck_go_r  <= 1'b0;
      blkpos_r <= '0;
      blkhit_r <= 1'b0;
    end else begin
      ck_go_r <= svc_w & ~es_w;
      if (ck_go_r) begin
        ck_r <= st_r;
      end
      if (bit_w) begin
        st_r.bits <= st_r.bits + 48'h1;
        blkpos_r  <= blk_end ? '0 : blkpos_r + 24'h1;
        blkhit_r  <= ~blk_end & (blkhit_r | err_w);
      end
      if (err_w) begin
        st_r.berr <= st_r.berr + 48'h1;
      end
      if (blk_end) begin
        st_r.blk <= st_r.blk + 32'h1;
        if (blkhit_r || err_w) begin
          st_r.blkerr <= st_r.blkerr + 32'h1;
        end
      end
      if (par_w) begin
        st_r.par <= st_r.par + 32'h1;
      end
      if (svc_w) begin
        st_r.ins <= st_r.ins + 32'h1;
        if (es_w) begin
          st_r.es <= st_r.es + 32'h1;
        end else begin
          st_r.efs <= st_r.efs + 32'h1;
        end
      end
    end
  end

  // elapsed time from first sync, never restored
  always_ff @(posedge CLK) begin
    if (RST || TEST_START) begin
      hr_r <= '0;
      mn_r <= '0;
      sc_r <= '0;
    end else if (tick_r && run_r && sync_r != bert_pkg::ST_WAIT) begin
      sc_r <= (sc_r == bert_pkg::SIXTY_M1) ? '0 : sc_r + 6'h1;
      if (sc_r == bert_pkg::SIXTY_M1) begin
        mn_r <= (mn_r == bert_pkg::SIXTY_M1) ? '0 : mn_r + 6'h1;
        if (mn_r == bert_pkg::SIXTY_M1) begin
          hr_r <= hr_r + 16'h1;
        end
      end
    end
  end

  // log evaluation at the tick, snapshot one cycle later
  always_ff @(posedge CLK) begin
    if (RST || TEST_START) begin
      log_go_r <= 1'b0;
      kind_r   <= '0;
      num_r    <= '0;
    end else begin
      log_go_r <= log_w;
      if (log_w) begin
        kind_r <= kind_w;
        num_r  <= num_r + 5'h1;
      end
    end
  end

  // event snapshot registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      LOG_VALID       <= 1'b0;
      LOG_NUM         <= '0;
      LOG_KIND        <= '0;
      LOG_BITS        <= '0;
      LOG_BIT_ERRS    <= '0;
      LOG_BER         <= '0;
      LOG_BLOCKS      <= '0;
      LOG_BLK_ERRS    <= '0;
      LOG_BLOCK_ERROR_RATIO        <= '0;
      LOG_PAR_ERRS    <= '0;
      LOG_SYNC_LOSSES <= '0;
      LOG_ERR_SECS    <= '0;
      LOG_EFS_PCT     <= '0;
      LOG_PWR_LOSSES  <= '0;
      LOG_HOURS       <= '0;
      LOG_MINUTES     <= '0;
      LOG_SECONDS     <= '0;
    end else begin
      LOG_VALID <= log_go_r;
      if (log_go_r) begin
        LOG_NUM         <= num_r;
        LOG_KIND        <= kind_r;
        LOG_BITS        <= st_r.bits;
        LOG_BIT_ERRS    <= st_r.berr;
        LOG_BER         <= frac(st_r.berr, st_r.bits);
        LOG_BLOCKS      <= st_r.blk;
        LOG_BLK_ERRS    <= st_r.blkerr;
        LOG_BLOCK_ERROR_RATIO        <= frac({16'h0, st_r.blkerr}, {16'h0, st_r.blk});
        LOG_PAR_ERRS    <= st_r.par;
        LOG_SYNC_LOSSES <= sl_r;
        LOG_ERR_SECS    <= st_r.es;
        LOG_EFS_PCT     <= pct(st_r.efs, st_r.ins);
        LOG_PWR_LOSSES  <= pl_r;
        LOG_HOURS       <= hr_r;
        LOG_MINUTES     <= mn_r;
        LOG_SECONDS     <= sc_r;
      end
    end
  end

  // printer skip marking; a new skip wins over the take
  wire es_log = log_go_r & kind_r[bert_pkg::K_ERRSEC] & PRINT_BUSY;
  always_ff @(posedge CLK) begin
    if (RST || TEST_START) begin
      ppend_r    <= 1'b0;
      PRINT_MARK <= 1'b0;
    end else begin
      ppend_r    <= es_log | (ppend_r & ~PRINT_TAKE);
      PRINT_MARK <= (es_log & ppend_r) | (PRINT_MARK & ~PRINT_TAKE);
    end
  end

  // current status display
  wire bert_pkg::state_t stat_w =
    !run_r       ? (ended_r ? bert_pkg::ST_END : bert_pkg::ST_WAIT) :
    pfail_r      ? bert_pkg::ST_PFAIL :
    dint_r       ? bert_pkg::ST_DINT :
    prest_show_r ? bert_pkg::ST_PREST : sync_r;
  always_ff @(posedge CLK) begin
    if (RST) begin
      TEST_STATE <= bert_pkg::ST_WAIT;
      RESYNC_REQ <= 1'b0;
    end else begin
      TEST_STATE <= stat_w;
      RESYNC_REQ <= loss_w;
    end
  end

endmodule
